/* File: src/mstp_cfg_defs.svh */
`ifndef MSTP_CFG_DEFS_SVH
`define MSTP_CFG_DEFS_SVH

// register byte offsets
`define OFS_PROTO 8'h00
`define OFS_NODE 8'h04
`define OFS_RATE 8'h08
`define OFS_LOSS 8'h0C
`define OFS_PCTREF 8'h10
`define OFS_ABMM 8'h14
`define OFS_MAXINFO 8'h18
`define OFS_INST_UP 8'h1C
`define OFS_INST_LO 8'h20
`define OFS_MONSEL 8'h24
`define OFS_APPLY 8'h28
`define OFS_STATUS 8'h2C
`define OFS_TOKCNT 8'h30
`define OFS_APDUCNT 8'h34
`define OFS_ERRCNT 8'h38
`define OFS_RXSTAT 8'h3C

// reset values of the settings
`define RST_PROTO 2'h0
`define RST_NODE 8'h00
`define RST_RATE 12'h0C0
`define RST_LOSS 14'h0000
`define RST_PCTREF 10'h03C
`define RST_ABMM 8'hFF
`define RST_MAXINFO 8'h01
`define RST_MONSEL 8'h00

// codes and limits
`define PROTO_NATIVE 2'h0
`define PROTO_MODBUS 2'h1
`define PROTO_MSTP 2'h2
`define NODE_MAX 8'h7F
`define LOSS_OFF 14'h270F
`define LOSS_MAX 14'h270E
`define COUNT_MAX 14'h270F
`define PCTREF_MIN 10'h001
`define PCTREF_MAX 10'h24E
`define INST_UP_MAX 10'h3E7
`define INST_LO_MAX 14'h270F
`define INST_LIMIT 24'h3FFFFE
`define INST_SCALE 14'h2710
`define AUTOBAUD_BIT 7
`define APPLY_BIT 0
`define MON_STATUS 8'h51
`define MON_TOKEN 8'h52
`define MON_APDU 8'h53
`define MON_ERROR 8'h54
`define RX_ERR_COMM 8'h5A
`define RX_ERR_PROTO 8'h5B
`define RATE_96 12'h060
`define RATE_192 12'h0C0
`define RATE_384 12'h180
`define RATE_576 12'h240
`define RATE_768 12'h300
`define RATE_1152 12'h480

// loss interval unit (0.1 s) and clock period, both in ns
`define LOSS_UNIT_NS 100000000
`define CLK_PERIOD_NS 100
`define LOSS_TICK_CYCLES (`LOSS_UNIT_NS / `CLK_PERIOD_NS)

`endif

/* File: src/mstp_cfg_pkg.sv */
package mstp_cfg_pkg;

	// pulses from the frame layer, one cycle each
	typedef struct packed {
		logic frame;
		logic token;
		logic apdu;
		logic error;
	} link_evt_t;

	// signal-loss supervisor states
	typedef enum logic [3:0] {
		LS_OFF = 4'b0001,
		LS_ARMED = 4'b0010,
		LS_WATCH = 4'b0100,
		LS_FAULT = 4'b1000
	} loss_state_t;

	typedef logic [3:0][13:0] mon_vals_t;

endpackage : mstp_cfg_pkg

/* File: src/bacnet_mstp_link_config.sv */
// Function
// - MS/TP runs only with protocol code 2; 1 is Modbus RTU, 0 native.
// - monitor selectors 81..84 show status, token, APDU and error counts.
// - token and valid APDU counters wrap to zero past 9999.
// - error counter saturates at 9999.
// - node address 0..127, initial 0, is own station number.
// - baud setting 96..1152 times 100 gives bit rate, initial 192.
// - interval 0: traffic served, output off once serial-command mode entered.
// - interval 0.1..999.8 s: output off after silence longer than interval.
// - interval 9999 disables signal-loss detection.
// - bit 7 of auto-baud/max-master enables auto baud; initial value 255.
// - bits 0..6 hold highest polled master address.
// - while holding token, send at most max-info-frames frames, 1..255, initial 1.
// - instance from upper and lower parts rejected unless 0..4194302.
// - upper 419 limits lower to 4302; lower 4303+ limits upper to 418.
// - out-of-range node or baud setting runs at its initial value.
// - active auto baud replaces configured rate by detected rate.
// - changed settings act only after an inverter reset; monitor selectors act at once.
// - percent reference 1..590 Hz, initial 60 Hz, is 100 percent reference.
// - handheld unit not serviced while MS/TP selected.
// - signal loss raises fault, shuts output off, asserts alarm.
// - any received frame clears loss timer, whatever its station.
// - loss timer starts at first frame in serial-command mode.
// - setting 128..255 starts auto baud at power-on or inverter reset; here only at the apply write, with protocol 2 set, none at power-on.
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`include "mstp_cfg_defs.svh"

module bacnet_mstp_link_config #(
	parameter int unsigned TICK_CYCLES = `LOSS_TICK_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// frame layer side
	input wire mstp_cfg_pkg::link_evt_t evt_i,
	input wire logic [7:0] rx_status_i,
	input wire logic token_held_i,
	input wire logic frame_sent_i,
	input wire logic autobaud_done_i,
	input wire logic [11:0] detected_rate_i,
	input wire logic serial_cmd_mode_i,
	// active settings
	output logic mstp_enable_o,
	output logic modbus_enable_o,
	output logic native_enable_o,
	output logic pu_service_o,
	output logic [6:0] station_o,
	output logic [11:0] line_rate_o,
	output logic autobaud_run_o,
	output logic [6:0] max_master_o,
	output logic tx_allow_o,
	output logic [21:0] instance_o,
	output logic [9:0] pct_ref_o,
	// supervision
	output logic output_shutoff_o,
	output logic link_loss_fault_o,
	output logic comm_alarm_output_o,
	output mstp_cfg_pkg::mon_vals_t mon_val_o
);
	import mstp_cfg_pkg::*;

	// ---------------------------------------------------------------
	// settings written by software (not yet in force, except the monitor selectors)
	// ---------------------------------------------------------------
	logic [1:0] protocol_select_setting_r;
	logic [7:0] node_address_setting_r;
	logic [11:0] line_rate_setting_r;
	logic [13:0] loss_check_interval_r;
	logic [9:0] percent_reference_frequency_r;
	logic [7:0] autobaud_maxmaster_setting_r;
	logic [7:0] max_info_frames_setting_r;
	logic [9:0] instance_upper_digits_r;
	logic [13:0] instance_lower_digits_r;
	logic [7:0] main_monitor_select_r;
	logic [7:0] panel_monitor_select_one_r;
	logic [7:0] panel_monitor_select_two_r;
	logic [7:0] panel_monitor_select_three_r;

	// settings in force since the last inverter reset
	logic [1:0] act_proto_r;
	logic [13:0] act_loss_r;
	logic [7:0] act_abmm_r;
	logic [7:0] act_maxinfo_r;
	logic [11:0] cfg_rate_r;

	// counters and supervision state
	logic [13:0] tok_cnt_r;
	logic [13:0] apdu_cnt_r;
	logic [13:0] err_cnt_r;
	logic [7:0] tx_cnt_r;
	logic [19:0] tick_cnt_r;
	logic [13:0] loss_cnt_r;
	loss_state_t loss_state_r;
	loss_state_t loss_state_nxt;
	logic detected_ok_r;
	logic [11:0] detected_r;
	logic ack_r;
	logic [31:0] rd_data_r;

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
	wire bus_wr = bus_req & wb_we_i & (|wb_sel_i);
	wire wr_proto = bus_wr & (wb_adr_i == `OFS_PROTO);
	wire wr_node = bus_wr & (wb_adr_i == `OFS_NODE);
	wire wr_rate = bus_wr & (wb_adr_i == `OFS_RATE);
	wire wr_loss = bus_wr & (wb_adr_i == `OFS_LOSS);
	wire wr_pct = bus_wr & (wb_adr_i == `OFS_PCTREF);
	wire wr_abmm = bus_wr & (wb_adr_i == `OFS_ABMM);
	wire wr_info = bus_wr & (wb_adr_i == `OFS_MAXINFO);
	wire wr_iup = bus_wr & (wb_adr_i == `OFS_INST_UP);
	wire wr_ilo = bus_wr & (wb_adr_i == `OFS_INST_LO);
	wire wr_msel = bus_wr & (wb_adr_i == `OFS_MONSEL);
	// inverter reset: the only way new settings except the monitor selectors come into force
	wire apply = bus_wr & (wb_adr_i == `OFS_APPLY) & wb_dat_i[`APPLY_BIT];

	// write values and range checks; rejected writes keep the old value
	wire [9:0] pct_wdata = wb_dat_i[9:0];
	wire pct_ok = (wb_dat_i[31:10] == 22'h0) && (pct_wdata >= `PCTREF_MIN)
		&& (pct_wdata <= `PCTREF_MAX);
	wire [13:0] loss_wdata = wb_dat_i[13:0];
	wire loss_ok = (wb_dat_i[31:14] == 18'h0)
		&& ((loss_wdata <= `LOSS_MAX) || (loss_wdata == `LOSS_OFF));
	wire info_ok = (wb_dat_i[31:8] == 24'h0) && (wb_dat_i[7:0] != 8'h00);

	// instance: upper*10000 + lower must stay within the limit
	wire [9:0] iup_new = wr_iup ? wb_dat_i[9:0] : instance_upper_digits_r;
	wire [13:0] ilo_new = wr_ilo ? wb_dat_i[13:0] : instance_lower_digits_r;
	wire [23:0] inst_sum = 24'(iup_new) * 24'(`INST_SCALE) + 24'(ilo_new);
	wire inst_wide_ok = (wb_dat_i[31:14] == 18'h0) && (wb_dat_i[13:10] == 4'h0 || wr_ilo);
	wire inst_ok = inst_wide_ok && (iup_new <= `INST_UP_MAX)
		&& (ilo_new <= `INST_LO_MAX) && (inst_sum <= `INST_LIMIT);

	// ---------------------------------------------------------------
	// application of settings at inverter reset
	// ---------------------------------------------------------------
	wire node_ok = (node_address_setting_r <= `NODE_MAX);
	wire rate_ok = (line_rate_setting_r == `RATE_96) || (line_rate_setting_r == `RATE_192)
		|| (line_rate_setting_r == `RATE_384) || (line_rate_setting_r == `RATE_576)
		|| (line_rate_setting_r == `RATE_768) || (line_rate_setting_r == `RATE_1152);
	// a bad value falls back to the initial value, never half-applied
	wire [6:0] node_use = node_ok ? node_address_setting_r[6:0] : 7'(`RST_NODE);
	wire [11:0] rate_use = rate_ok ? line_rate_setting_r : `RST_RATE;
	wire autobaud_en = autobaud_maxmaster_setting_r[`AUTOBAUD_BIT];
	wire mstp_on = (act_proto_r == `PROTO_MSTP);

	// ---------------------------------------------------------------
	// event qualification
	// ---------------------------------------------------------------
	wire tok_ev = mstp_on & evt_i.token;
	wire apdu_ev = mstp_on & evt_i.apdu;
	// errors seen while hunting for the rate are not counted
	wire err_ev = mstp_on & evt_i.error & ~autobaud_run_o;
	// any frame clears the timer regardless of destination station
	wire frame_ev = mstp_on & evt_i.frame;
	wire tick = (tick_cnt_r == 20'(TICK_CYCLES - 1));
	wire loss_off = (act_loss_r == `LOSS_OFF);
	wire loss_zero = (act_loss_r == 14'h0000);

	// ---------------------------------------------------------------
	// bus read mux
	// ---------------------------------------------------------------
	wire [31:0] status_word = {24'h0, detected_ok_r, autobaud_run_o, comm_alarm_output_o,
		output_shutoff_o, loss_state_r};
	wire [31:0] monsel_word = {panel_monitor_select_three_r, panel_monitor_select_two_r,
		panel_monitor_select_one_r, main_monitor_select_r};
	logic [31:0] rd_mux;
	always_comb begin
		if (wb_adr_i == `OFS_PROTO) rd_mux = {30'h0, protocol_select_setting_r};
		else if (wb_adr_i == `OFS_NODE) rd_mux = {24'h0, node_address_setting_r};
		else if (wb_adr_i == `OFS_RATE) rd_mux = {20'h0, line_rate_setting_r};
		else if (wb_adr_i == `OFS_LOSS) rd_mux = {18'h0, loss_check_interval_r};
		else if (wb_adr_i == `OFS_PCTREF) rd_mux = {22'h0, percent_reference_frequency_r};
		else if (wb_adr_i == `OFS_ABMM) rd_mux = {24'h0, autobaud_maxmaster_setting_r};
		else if (wb_adr_i == `OFS_MAXINFO) rd_mux = {24'h0, max_info_frames_setting_r};
		else if (wb_adr_i == `OFS_INST_UP) rd_mux = {22'h0, instance_upper_digits_r};
		else if (wb_adr_i == `OFS_INST_LO) rd_mux = {18'h0, instance_lower_digits_r};
		else if (wb_adr_i == `OFS_MONSEL) rd_mux = monsel_word;
		else if (wb_adr_i == `OFS_STATUS) rd_mux = status_word;
		else if (wb_adr_i == `OFS_TOKCNT) rd_mux = {18'h0, tok_cnt_r};
		else if (wb_adr_i == `OFS_APDUCNT) rd_mux = {18'h0, apdu_cnt_r};
		else if (wb_adr_i == `OFS_ERRCNT) rd_mux = {18'h0, err_cnt_r};
		else if (wb_adr_i == `OFS_RXSTAT) rd_mux = {24'h0, rx_status_i};
		else rd_mux = 32'h0;
	end

	// single-wait-state answer; ack drops the cycle after it is given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			rd_data_r <= 32'h0;
		end else begin
			ack_r <= bus_req;
			rd_data_r <= bus_req ? rd_mux : 32'h0;
		end
	end

	// ---------------------------------------------------------------
	// software setting registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			protocol_select_setting_r <= `RST_PROTO;
			node_address_setting_r <= `RST_NODE;
			line_rate_setting_r <= `RST_RATE;
			loss_check_interval_r <= `RST_LOSS;
			percent_reference_frequency_r <= `RST_PCTREF;
			autobaud_maxmaster_setting_r <= `RST_ABMM;
			max_info_frames_setting_r <= `RST_MAXINFO;
			instance_upper_digits_r <= 10'h0;
			instance_lower_digits_r <= 14'h0;
		end else begin
			if (wr_proto && wb_dat_i[31:2] == 30'h0 && wb_dat_i[1:0] != 2'h3)
				protocol_select_setting_r <= wb_dat_i[1:0];
			// node and rate store anything; the range check acts at reset
			if (wr_node) node_address_setting_r <= wb_dat_i[7:0];
			if (wr_rate) line_rate_setting_r <= wb_dat_i[11:0];
			if (wr_loss && loss_ok) loss_check_interval_r <= loss_wdata;
			if (wr_pct && pct_ok) percent_reference_frequency_r <= pct_wdata;
			if (wr_abmm) autobaud_maxmaster_setting_r <= wb_dat_i[7:0];
			if (wr_info && info_ok) max_info_frames_setting_r <= wb_dat_i[7:0];
			if ((wr_iup || wr_ilo) && inst_ok) begin
				instance_upper_digits_r <= iup_new;
				instance_lower_digits_r <= ilo_new;
			end
		end
	end

	// monitor selectors act immediately, they are panel settings
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_monitor_select_r <= `RST_MONSEL;
			panel_monitor_select_one_r <= `RST_MONSEL;
			panel_monitor_select_two_r <= `RST_MONSEL;
			panel_monitor_select_three_r <= `RST_MONSEL;
		end else if (wr_msel) begin
			if (wb_sel_i[0]) main_monitor_select_r <= wb_dat_i[7:0];
			if (wb_sel_i[1]) panel_monitor_select_one_r <= wb_dat_i[15:8];
			if (wb_sel_i[2]) panel_monitor_select_two_r <= wb_dat_i[23:16];
			if (wb_sel_i[3]) panel_monitor_select_three_r <= wb_dat_i[31:24];
		end
	end

	// ---------------------------------------------------------------
	// settings in force, loaded only at inverter reset
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_proto_r <= `RST_PROTO;
			act_loss_r <= `RST_LOSS;
			act_abmm_r <= `RST_ABMM;
			act_maxinfo_r <= `RST_MAXINFO;
			cfg_rate_r <= `RST_RATE;
			station_o <= 7'(`RST_NODE);
			instance_o <= 22'h0;
			pct_ref_o <= `RST_PCTREF;
		end else if (apply) begin
			act_proto_r <= protocol_select_setting_r;
			act_loss_r <= loss_check_interval_r;
			act_abmm_r <= autobaud_maxmaster_setting_r;
			act_maxinfo_r <= max_info_frames_setting_r;
			cfg_rate_r <= rate_use;
			station_o <= node_use;
			instance_o <= inst_sum[21:0] - 22'(ilo_new) + 22'(instance_lower_digits_r);
			pct_ref_o <= percent_reference_frequency_r;
		end
	end

	// protocol selects and the handheld unit lockout
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mstp_enable_o <= 1'b0;
			modbus_enable_o <= 1'b0;
			native_enable_o <= 1'b1;
			pu_service_o <= 1'b1;
			max_master_o <= 7'(`RST_ABMM);
		end else begin
			mstp_enable_o <= mstp_on;
			modbus_enable_o <= (act_proto_r == `PROTO_MODBUS);
			native_enable_o <= (act_proto_r == `PROTO_NATIVE);
			pu_service_o <= ~mstp_on;
			max_master_o <= act_abmm_r[6:0];
		end
	end

	// ---------------------------------------------------------------
	// automatic baud recognition
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			autobaud_run_o <= 1'b0;
			detected_ok_r <= 1'b0;
			detected_r <= `RST_RATE;
			line_rate_o <= `RST_RATE;
		end else begin
			if (apply) begin
				// power-on starts no auto baud; only the apply write starts it
				autobaud_run_o <= autobaud_en & (protocol_select_setting_r == `PROTO_MSTP);
				detected_ok_r <= 1'b0;
			end else if (autobaud_run_o && autobaud_done_i) begin
				autobaud_run_o <= 1'b0;
				detected_ok_r <= 1'b1;
				detected_r <= detected_rate_i;
			end
			line_rate_o <= (detected_ok_r && act_abmm_r[`AUTOBAUD_BIT]) ? detected_r
				: cfg_rate_r;
		end
	end

	// ---------------------------------------------------------------
	// panel counters
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || apply) begin
			tok_cnt_r <= 14'h0;
			apdu_cnt_r <= 14'h0;
			err_cnt_r <= 14'h0;
		end else begin
			if (tok_ev) tok_cnt_r <= (tok_cnt_r == `COUNT_MAX) ? 14'h0 : tok_cnt_r + 14'h1;
			if (apdu_ev) apdu_cnt_r <= (apdu_cnt_r == `COUNT_MAX) ? 14'h0
				: apdu_cnt_r + 14'h1;
			if (err_ev && err_cnt_r != `COUNT_MAX) err_cnt_r <= err_cnt_r + 14'h1;
		end
	end

	// panel monitor values, one per selector
	wire [3:0][7:0] mon_sel = monsel_word;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mon
			wire [13:0] mon_pick = (mon_sel[gi] == `MON_STATUS) ? {6'h0, rx_status_i}
				: (mon_sel[gi] == `MON_TOKEN) ? tok_cnt_r
				: (mon_sel[gi] == `MON_APDU) ? apdu_cnt_r
				: (mon_sel[gi] == `MON_ERROR) ? err_cnt_r : 14'h0;
			always_ff @(posedge clk_i) begin
				if (rst_i) mon_val_o[gi] <= 14'h0;
				else mon_val_o[gi] <= mon_pick;
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// frames per token hold
	// ---------------------------------------------------------------
	wire [7:0] tx_cnt_inc = tx_cnt_r + 8'h1;
	always_ff @(posedge clk_i) begin
		if (rst_i || !token_held_i) begin
			tx_cnt_r <= 8'h0;
			tx_allow_o <= 1'b0;
		end else begin
			if (frame_sent_i && tx_allow_o) tx_cnt_r <= tx_cnt_inc;
			// allow drops right after the last permitted frame
			tx_allow_o <= mstp_on && ((frame_sent_i && tx_allow_o) ? tx_cnt_inc < act_maxinfo_r
				: tx_cnt_r < act_maxinfo_r);
		end
	end

	// ---------------------------------------------------------------
	// signal-loss supervisor
	// ---------------------------------------------------------------
	always_comb begin
		loss_state_nxt = loss_state_r;
		case (loss_state_r)
			LS_OFF: begin
				if (mstp_on && serial_cmd_mode_i && !loss_off)
					loss_state_nxt = loss_zero ? LS_FAULT : LS_ARMED;
			end
			LS_ARMED: begin
				if (!serial_cmd_mode_i) loss_state_nxt = LS_OFF;
				else if (frame_ev) loss_state_nxt = LS_WATCH;
			end
			LS_WATCH: begin
				if (!serial_cmd_mode_i) loss_state_nxt = LS_OFF;
				else if (!frame_ev && loss_cnt_r == act_loss_r) loss_state_nxt = LS_FAULT;
			end
			LS_FAULT: loss_state_nxt = LS_FAULT;
			default: loss_state_nxt = LS_OFF;
		endcase
	end

	// timer counts 0.1 s units since the last frame
	always_ff @(posedge clk_i) begin
		if (rst_i || apply) begin
			loss_state_r <= LS_OFF;
			tick_cnt_r <= 20'h0;
			loss_cnt_r <= 14'h0;
		end else begin
			loss_state_r <= loss_state_nxt;
			if (frame_ev || loss_state_r != LS_WATCH) begin
				tick_cnt_r <= 20'h0;
				loss_cnt_r <= 14'h0;
			end else begin
				tick_cnt_r <= tick ? 20'h0 : tick_cnt_r + 20'h1;
				if (tick) loss_cnt_r <= loss_cnt_r + 14'h1;
			end
		end
	end

	// fault, shutoff and alarm; fault holds until inverter reset
	wire rx_bad = mstp_on && (rx_status_i == `RX_ERR_COMM || rx_status_i == `RX_ERR_PROTO);
	always_ff @(posedge clk_i) begin
		if (rst_i || apply) begin
			link_loss_fault_o <= 1'b0;
			output_shutoff_o <= 1'b0;
			comm_alarm_output_o <= 1'b0;
		end else begin
			link_loss_fault_o <= (loss_state_nxt == LS_FAULT);
			output_shutoff_o <= (loss_state_nxt == LS_FAULT);
			comm_alarm_output_o <= (loss_state_nxt == LS_FAULT) || rx_bad;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rd_data_r;

endmodule : bacnet_mstp_link_config

/* File: sim/bacnet_mstp_link_config_properties.sv */
module mstp_cfg_checker (
	// bus and protocol view
	input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
	input wire logic [7:0] wb_adr_i,
	input wire logic mstp_enable_o, modbus_enable_o, native_enable_o, pu_service_o,
	// supervision view
	input wire logic token_held_i, tx_allow_o, link_loss_fault_o,
	input wire logic output_shutoff_o, comm_alarm_output_o,
	input wire logic [21:0] instance_o,
	input wire logic [9:0] pct_ref_o,
	input wire mstp_cfg_pkg::mon_vals_t mon_val_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// apply strobe: the only bus event allowed to clear a fault
	wire apply_w = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h28;
	// request taken, then one-cycle answer
	sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_answer; wb_ack_o ##1 !wb_ack_o; endsequence
	property p_ack_wait; s_take |=> s_answer; endproperty
	a_ack_wait: assert property (p_ack_wait) else $error("bus answer missing");
	property p_proto_one; $onehot({mstp_enable_o, modbus_enable_o, native_enable_o}); endproperty
	a_proto_one: assert property (p_proto_one) else $error("protocol not unique");
	property p_pu_off; pu_service_o != mstp_enable_o; endproperty
	a_pu_off: assert property (p_pu_off) else $error("handheld served in mstp");
	property p_fault_out; link_loss_fault_o |-> output_shutoff_o && comm_alarm_output_o; endproperty
	a_fault_out: assert property (p_fault_out) else $error("fault without shutoff");
	property p_fault_hold; link_loss_fault_o && !apply_w |=> link_loss_fault_o; endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault dropped");
	property p_token_drop; !token_held_i |=> !tx_allow_o; endproperty
	a_token_drop: assert property (p_token_drop) else $error("send without token");
	property p_inst_range; instance_o <= 22'h3FFFFE; endproperty
	a_inst_range: assert property (p_inst_range) else $error("instance too big");
	property p_pct_range; pct_ref_o inside {[10'h001:10'h24E]}; endproperty
	a_pct_range: assert property (p_pct_range) else $error("reference out of range");
	property p_mon_range; mon_val_o[0] <= 14'h270F && mon_val_o[1] <= 14'h270F
		&& mon_val_o[2] <= 14'h270F && mon_val_o[3] <= 14'h270F; endproperty
	a_mon_range: assert property (p_mon_range) else $error("monitor over 9999");
endmodule : mstp_cfg_checker

bind bacnet_mstp_link_config mstp_cfg_checker mstp_cfg_checker_inst (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_ack_o, .wb_adr_i, .mstp_enable_o, .modbus_enable_o, .native_enable_o,
	.pu_service_o, .token_held_i, .tx_allow_o, .link_loss_fault_o, .output_shutoff_o,
	.comm_alarm_output_o, .instance_o, .pct_ref_o, .mon_val_o);

/* File: sim/mstp_frame_model.sv */
module mstp_frame_model (
	// clock and device view
	input wire logic clk_i,
	input wire logic tx_allow_i,
	// frame layer outputs
	output mstp_cfg_pkg::link_evt_t evt_o,
	output logic token_held_o,
	output logic frame_sent_o,
	output logic autobaud_done_o,
	output logic [11:0] detected_rate_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import mstp_cfg_pkg::*;
	logic [11:0] rate_r = 12'h000;
	// idle rate bus never repeats the last valid value
	assign detected_rate_o = autobaud_done_o ? rate_r : ~rate_r;
	initial begin
		evt_o = '0;
		token_held_o = 1'b0;
		frame_sent_o = 1'b0;
		autobaud_done_o = 1'b0;
	end
	// n back-to-back event pulses
	task automatic pulse(input link_evt_t e, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			evt_o <= e;
		end
		@(posedge clk_i);
		evt_o <= '0;
	endtask : pulse
	// hold the token; a gap cycle after each frame lets allow settle
	task automatic token(input int cycles, output int sent);
		sent = 0;
		@(posedge clk_i);
		token_held_o <= 1'b1;
		repeat (cycles) begin
			@(posedge clk_i);
			if (tx_allow_i && !frame_sent_o) sent++;
			frame_sent_o <= tx_allow_i && !frame_sent_o;
		end
		@(posedge clk_i);
		frame_sent_o <= 1'b0;
		token_held_o <= 1'b0;
	endtask : token
	// report a detected line rate
	task automatic baud(input logic [11:0] rate);
		@(posedge clk_i);
		rate_r <= rate;
		autobaud_done_o <= 1'b1;
		@(posedge clk_i);
		autobaud_done_o <= 1'b0;
	endtask : baud
endmodule : mstp_frame_model

/* File: sim/bacnet_mstp_link_config_test.sv */
module bacnet_mstp_link_config_test;
	timeunit 1ns;
	timeprecision 1ns;
	import mstp_cfg_pkg::*;
	typedef struct packed {logic [7:0] adr; logic we; logic [31:0] dat; logic [31:0] exp;} row_t;
	logic clk_i = 1'b0, rst_i = 1'b1, serial_cmd_mode_i = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h00, rx_status_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	link_evt_t evt_i;
	logic token_held_i, frame_sent_i, autobaud_done_i, tx_allow_o, autobaud_run_o;
	logic [11:0] detected_rate_i, line_rate_o;
	logic mstp_enable_o, modbus_enable_o, native_enable_o, pu_service_o;
	logic [6:0] station_o, max_master_o;
	logic [21:0] instance_o;
	logic [9:0] pct_ref_o;
	logic output_shutoff_o, link_loss_fault_o, comm_alarm_output_o;
	mon_vals_t mon_val_o;
	int fails = 0, total_checks = 0, cycles = 0, sent;
	logic [31:0] d;
	// register rows: reset reads, then write and read back
	row_t rows [20] = '{'{8'h14, 0, 0, 32'hFF}, '{8'h18, 0, 0, 32'h1}, '{8'h08, 0, 0, 32'hC0},
		'{8'h04, 0, 0, 32'h0}, '{8'h00, 1, 2, 32'h2}, '{8'h00, 1, 3, 32'h2},
		'{8'h04, 1, 5, 32'h5}, '{8'h08, 1, 32'h60, 32'h60}, '{8'h0C, 1, 3, 32'h3},
		'{8'h10, 1, 32'h24E, 32'h24E}, '{8'h10, 1, 0, 32'h24E}, '{8'h14, 1, 5, 32'h5},
		'{8'h18, 1, 3, 32'h3}, '{8'h18, 1, 0, 32'h3}, '{8'h1C, 1, 32'h1A3, 32'h1A3},
		'{8'h20, 1, 32'h10CE, 32'h10CE}, '{8'h20, 1, 32'h10CF, 32'h10CE},
		'{8'h1C, 1, 32'h1A4, 32'h1A3}, '{8'h24, 1, 32'h51545352, 32'h51545352},
		'{8'h40, 1, 32'h55, 32'h0}};
	bacnet_mstp_link_config #(.TICK_CYCLES(10)) bacnet_mstp_link_config_inst (.clk_i, .rst_i,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.evt_i, .rx_status_i, .token_held_i, .frame_sent_i, .autobaud_done_i, .detected_rate_i,
		.serial_cmd_mode_i, .mstp_enable_o, .modbus_enable_o, .native_enable_o, .pu_service_o,
		.station_o, .line_rate_o, .autobaud_run_o, .max_master_o, .tx_allow_o, .instance_o,
		.pct_ref_o, .output_shutoff_o, .link_loss_fault_o, .comm_alarm_output_o, .mon_val_o);
	mstp_frame_model mstp_frame_model_inst (.clk_i, .tx_allow_i(tx_allow_o), .evt_o(evt_i),
		.token_held_o(token_held_i), .frame_sent_o(frame_sent_i),
		.autobaud_done_o(autobaud_done_i), .detected_rate_o(detected_rate_i));
	// clock and hang guard
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			end_of_test();
		end
	end
	task automatic chk(input logic [55:0] got, input logic [55:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask : chk
	// one classic cycle; data taken at the ack edge
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= 4'hF;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		d = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : bus
	// inverter reset through the apply register
	task automatic apply();
		bus(1'b1, 8'h28, 32'h1);
		repeat (3) @(posedge clk_i);
	endtask : apply
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(negedge clk_i);
		chk(native_enable_o, 1);
		chk(pct_ref_o, 10'h03C);
		chk(max_master_o, 7'h7F);
		foreach (rows[i]) begin
			if (rows[i].we) bus(1'b1, rows[i].adr, rows[i].dat);
			bus(1'b0, rows[i].adr, 0);
			chk(d, rows[i].exp);
		end
		chk(station_o, 0);
		apply();
		chk({mstp_enable_o, pu_service_o, autobaud_run_o}, 3'h4);
		chk({station_o, max_master_o, line_rate_o}, {7'h5, 7'h5, 12'h060});
		chk({instance_o, pct_ref_o}, {22'h3FFFFE, 10'h24E});
		$display("settings test done");
		rx_status_i <= 8'h0A;
		mstp_frame_model_inst.pulse(4'b0111, 10001);
		bus(1'b0, 8'h30, 0);
		chk(d, 1);
		bus(1'b0, 8'h38, 0);
		chk(d, 32'h270F);
		@(negedge clk_i);
		chk(mon_val_o, {14'hA, 14'h270F, 14'h1, 14'h1});
		mstp_frame_model_inst.token(20, sent);
		chk(sent, 3);
		$display("counter test done");
		serial_cmd_mode_i <= 1'b1;
		repeat (60) @(posedge clk_i);
		chk(link_loss_fault_o, 0);
		repeat (4) mstp_frame_model_inst.pulse(4'b1000, 1);
		repeat (4) @(posedge clk_i);
		chk(link_loss_fault_o, 0);
		repeat (40) @(posedge clk_i);
		chk({link_loss_fault_o, output_shutoff_o, comm_alarm_output_o}, 3'h7);
		serial_cmd_mode_i <= 1'b0;
		bus(1'b1, 8'h0C, 0);
		apply();
		chk(output_shutoff_o, 0);
		serial_cmd_mode_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(output_shutoff_o, 1);
		serial_cmd_mode_i <= 1'b0;
		bus(1'b1, 8'h0C, 32'h270F);
		apply();
		serial_cmd_mode_i <= 1'b1;
		mstp_frame_model_inst.pulse(4'b1000, 1);
		repeat (60) @(negedge clk_i);
		chk(output_shutoff_o, 0);
		$display("loss test done");
		bus(1'b1, 8'h04, 32'hC8);
		bus(1'b1, 8'h08, 32'h64);
		apply();
		chk({station_o, line_rate_o}, {7'h0, 12'h0C0});
		bus(1'b0, 8'h30, 0);
		chk(d, 0);
		bus(1'b1, 8'h14, 32'h85);
		apply();
		chk(autobaud_run_o, 1);
		mstp_frame_model_inst.baud(12'h480);
		repeat (3) @(negedge clk_i);
		chk(line_rate_o, 12'h480);
		bus(1'b1, 8'h00, 1);
		apply();
		chk({modbus_enable_o, pu_service_o}, 2'h3);
		$display("mode test done");
		end_of_test();
	end
endmodule : bacnet_mstp_link_config_test
